//--- design/ocpp_pkg.sv
// constants and types for the output compare pulse and pwm channel
`default_nettype none
package ocpp_pkg;
  localparam logic [7:0] OFS_CTL   = 8'h00;
  localparam logic [7:0] OFS_PRI   = 8'h04;
  localparam logic [7:0] OFS_SEC   = 8'h08;
  localparam logic [7:0] OFS_PER_A = 8'h0c;
  localparam logic [7:0] OFS_PER_B = 8'h10;
  localparam logic [7:0] OFS_CNT_A = 8'h14;
  localparam logic [7:0] OFS_CNT_B = 8'h18;
  localparam logic [7:0] OFS_TBC_A = 8'h1c;
  localparam logic [7:0] OFS_TBC_B = 8'h20;
  localparam logic [7:0] OFS_IRQ   = 8'h24;

  localparam int BIT_MODE = 0;
  localparam int BIT_TSEL = 3;
  localparam int BIT_FLT  = 4;
  localparam int BIT_HALT = 13;
  localparam int BIT_RUN  = 15;
  localparam int BIT_FLAG = 0;
  localparam int BIT_IEN  = 1;

  localparam logic [2:0] MODE_OFF  = 3'h0;
  localparam logic [2:0] MODE_ONE  = 3'h4;
  localparam logic [2:0] MODE_CONT = 3'h5;
  localparam logic [2:0] MODE_PWMF = 3'h7;

  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       halt_when_idle;
    logic       time_base_select;
    logic [2:0] compare_mode_field;
  } ocpp_ctl_s;

  typedef enum logic [2:0] {
    st_off,
    st_rise,
    st_fall,
    st_done,
    st_pwm
  } ocpp_state_e;
endpackage
`default_nettype wire

//--- design/ocpp_top.sv
// output compare channel with pulse and pwm modes, two time bases, axi4-lite slave
// How it works
// RQ1 - one-shot code written: pin forced low, then exactly one pulse
// RQ2 - pulse modes: first primary match drives pin high
// RQ3 - one-shot: secondary match drives pin low, no further pulses
// RQ4 - secondary match sets flag; request only when enable set
// RQ5 - rewriting one-shot code after a pulse starts a new pulse
// RQ6 - continuous code: pin low at setup, one pulse every period
// RQ7 - continuous: flag set on every secondary match
// RQ8 - time base at period value returns to zero and keeps counting
// RQ9 - software keeps period at least the secondary compare value
// RQ10 - select bit picks which time base feeds the compare
// RQ11 - software sets the run bit of the selected time base
// RQ12 - period value N gives pwm period of N plus one counts
// RQ13 - secondary writable anytime; copied to primary at period match
// RQ14 - primary register ignores writes while pwm is active
// RQ15 - primary value at enable sets first pwm period duty
// RQ16 - software loads primary with initial duty before enabling pwm
// RQ17 - duty zero keeps pin low all period
// RQ18 - duty above period keeps pin high
// RQ19 - duty equal period: pin low for exactly one count
// RQ20 - software enables the channel interrupt to use the fault input
// RQ21 - pwm-with-fault: fault sets read-only status, hardware clears it
// RQ22 - halt bit stops the channel while processor idles
// RQ23 - pwm high from wrap to zero, low once count reaches duty
// RQ24 - 16-bit equality matches; pin changes the cycle after
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`default_nettype none

module ocpp_timebase
  import ocpp_pkg::*;
(
  input  wire logic        mclk,   // clock
  input  wire logic        rst,    // sync reset
  input  wire logic        run,    // count enable
  input  wire logic [15:0] period, // period value
  output logic      [15:0] count   // current count
);
  wire wrap = (count == period);

  always_ff @(posedge mclk)
  begin
    if (rst)
      count <= RST_REG16;
    // RQ8 wrap to zero
    else if (run)
      count <= wrap ? RST_REG16 : count + 16'h0001;
  end

  AST_WRAP: assert property (@(posedge mclk) disable iff (rst) // RQ8
    run && wrap |=> count == RST_REG16)
    else $error("time base did not return to zero");
endmodule

module ocpp_top
  import ocpp_pkg::*;
(
  input  wire logic        mclk,              // clock, 50 MHz
  input  wire logic        rst,               // sync reset, high
  input  wire logic [7:0]  s_axi_awaddr,      // write address
  input  wire logic        s_axi_awvalid,     // write address valid
  output logic             s_axi_awready,     // write address ready
  input  wire logic [31:0] s_axi_wdata,       // write data
  input  wire logic [3:0]  s_axi_wstrb,       // byte enables
  input  wire logic        s_axi_wvalid,      // write data valid
  output logic             s_axi_wready,      // write data ready
  output logic [1:0]       s_axi_bresp,       // write response
  output logic             s_axi_bvalid,      // write response valid
  input  wire logic        s_axi_bready,      // write response ready
  input  wire logic [7:0]  s_axi_araddr,      // read address
  input  wire logic        s_axi_arvalid,     // read address valid
  output logic             s_axi_arready,     // read address ready
  output logic [31:0]      s_axi_rdata,       // read data
  output logic [1:0]       s_axi_rresp,       // read response
  output logic             s_axi_rvalid,      // read data valid
  input  wire logic        s_axi_rready,      // read data ready
  input  wire logic        fault_in,          // pwm fault, high
  input  wire logic        cpu_idle,          // processor idle
  output logic             compare_output_pin, // compare output
  output logic             irq_req            // interrupt request
);
  function automatic logic [15:0] ocpp_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  ocpp_ctl_s   ctl_r;
  ocpp_state_e st_r;
  ocpp_state_e st_nxt;
  logic [15:0] pri_r;
  logic [15:0] sec_r;
  logic [15:0] per_a_r;
  logic [15:0] per_b_r;
  logic        run_a_r;
  logic        run_b_r;
  logic        flt_r;
  logic        flag_r;
  logic        ien_r;
  logic        aw_free_r;
  logic        w_free_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  logic        pin_nxt;
  logic        set_flag;
  logic [15:0] ctl_word;
  logic [15:0] rd_val;
  logic        rd_err;
  logic        wr_err;

  ocpp_timebase u_tb_a (
    .mclk   (mclk),
    .rst    (rst),
    .run    (run_a_r),
    .period (per_a_r),
    .count  (cnt_a)
  );

  ocpp_timebase u_tb_b (
    .mclk   (mclk),
    .rst    (rst),
    .run    (run_b_r),
    .period (per_b_r),
    .count  (cnt_b)
  );

  // write path decode
  wire        wr_do   = !aw_free_r && !w_free_r && !s_axi_bvalid;
  wire        w_ctl   = wr_do && awaddr_r == OFS_CTL;
  wire        w_pri   = wr_do && awaddr_r == OFS_PRI;
  wire        w_sec   = wr_do && awaddr_r == OFS_SEC;
  wire        w_per_a = wr_do && awaddr_r == OFS_PER_A;
  wire        w_per_b = wr_do && awaddr_r == OFS_PER_B;
  wire        w_tbc_a = wr_do && awaddr_r == OFS_TBC_A;
  wire        w_tbc_b = wr_do && awaddr_r == OFS_TBC_B;
  wire        w_irq   = wr_do && awaddr_r == OFS_IRQ;
  wire [15:0] ctl_m   = ocpp_merge(ctl_word, wdata_r, wstrb_r);
  // low byte write re-initialises the channel
  wire        ctl_wr  = w_ctl && wstrb_r[0];
  wire [2:0]  new_mode = ctl_m[BIT_MODE +: 3];
  wire        ar_take = s_axi_arvalid && s_axi_arready;

  // RQ10 time base select
  wire [15:0] cnt_sel = ctl_r.time_base_select ? cnt_b : cnt_a;
  wire [15:0] per_sel = ctl_r.time_base_select ? per_b_r : per_a_r;
  wire        run_sel = ctl_r.time_base_select ? run_b_r : run_a_r;
  // RQ24 equality matches
  wire        pri_hit = run_sel && cnt_sel == pri_r;
  wire        sec_hit = run_sel && cnt_sel == sec_r;
  wire        per_hit = cnt_sel == per_sel;
  // RQ22 idle halt
  wire        halted  = ctl_r.halt_when_idle && cpu_idle;
  wire        active  = !ctl_wr && !halted;
  wire        one_m   = ctl_r.compare_mode_field == MODE_ONE;
  wire        cont_m  = ctl_r.compare_mode_field == MODE_CONT;
  wire        pwm_m   = ctl_r.compare_mode_field[2:1] == 2'b11;
  wire        flt_m   = ctl_r.compare_mode_field == MODE_PWMF;
  wire        flt_blk = flt_m && (fault_in || flt_r);
  wire        d_load  = active && st_r == st_pwm && per_hit;
  wire        flt_set = active && st_r == st_pwm && flt_m && fault_in;
  wire        flag_clr = w_irq && wstrb_r[0] && wdata_r[BIT_FLAG];
  // set wins over software clear
  wire        flag_nxt = set_flag || (flag_r && !flag_clr);

  always_comb
  begin
    ctl_word = RST_REG16;
    ctl_word[BIT_MODE +: 3] = ctl_r.compare_mode_field;
    ctl_word[BIT_TSEL] = ctl_r.time_base_select;
    ctl_word[BIT_FLT] = flt_r;
    ctl_word[BIT_HALT] = ctl_r.halt_when_idle;
  end

  // channel sequencer
  always_comb
  begin
    st_nxt = st_r;
    pin_nxt = compare_output_pin;
    set_flag = flt_set;
    if (ctl_wr)
    begin
      // RQ1 RQ5 RQ6 force low and arm
      pin_nxt = 1'b0;
      if (new_mode == MODE_ONE || new_mode == MODE_CONT)
        st_nxt = st_rise;
      else if (new_mode[2:1] == 2'b11)
        st_nxt = st_pwm;
      else
        st_nxt = st_off;
    end
    else if (!halted)
    begin
      // RQ7 flag on every secondary match
      if (cont_m && sec_hit)
        set_flag = 1'b1;
      case (st_r)
        st_rise:
        begin
          // RQ2 leading edge
          if (pri_hit)
          begin
            pin_nxt = 1'b1;
            st_nxt = st_fall;
          end
        end
        st_fall:
        begin
          // RQ3 RQ4 trailing edge and flag
          if (sec_hit)
          begin
            pin_nxt = 1'b0;
            set_flag = 1'b1;
            st_nxt = one_m ? st_done : st_rise;
          end
        end
        st_pwm:
        begin
          // RQ12 RQ17 RQ18 RQ19 RQ23 level from count against duty
          pin_nxt = !flt_blk && cnt_sel < pri_r;
        end
        default:
        begin
          pin_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r <= st_off;
      compare_output_pin <= 1'b0;
      ctl_r <= '0;
      flt_r <= 1'b0;
      flag_r <= 1'b0;
      irq_req <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      compare_output_pin <= pin_nxt;
      // RQ21 fault status, cleared by hardware on rewrite
      flt_r <= !ctl_wr && (flt_r || flt_set);
      flag_r <= flag_nxt;
      // RQ4 gated request
      irq_req <= flag_nxt && ien_r;
      if (w_ctl)
        ctl_r <= '{ctl_m[BIT_HALT], ctl_m[BIT_TSEL], ctl_m[BIT_MODE +: 3]};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pri_r <= RST_REG16;
      sec_r <= RST_REG16;
      per_a_r <= RST_REG16;
      per_b_r <= RST_REG16;
      run_a_r <= 1'b0;
      run_b_r <= 1'b0;
      ien_r <= 1'b0;
    end
    else
    begin
      // RQ13 RQ15 duty double buffer
      if (d_load)
        pri_r <= sec_r;
      // RQ14 primary read-only in pwm
      else if (w_pri && !pwm_m)
        pri_r <= ocpp_merge(pri_r, wdata_r, wstrb_r);
      if (w_sec)
        sec_r <= ocpp_merge(sec_r, wdata_r, wstrb_r);
      if (w_per_a)
        per_a_r <= ocpp_merge(per_a_r, wdata_r, wstrb_r);
      if (w_per_b)
        per_b_r <= ocpp_merge(per_b_r, wdata_r, wstrb_r);
      if (w_tbc_a && wstrb_r[1])
        run_a_r <= wdata_r[BIT_RUN];
      if (w_tbc_b && wstrb_r[1])
        run_b_r <= wdata_r[BIT_RUN];
      if (w_irq && wstrb_r[0])
        ien_r <= wdata_r[BIT_IEN];
    end
  end

  // read decode
  always_comb
  begin
    rd_val = RST_REG16;
    rd_err = 1'b0;
    if (s_axi_araddr == OFS_CTL)
      rd_val = ctl_word;
    else if (s_axi_araddr == OFS_PRI)
      rd_val = pri_r;
    else if (s_axi_araddr == OFS_SEC)
      rd_val = sec_r;
    else if (s_axi_araddr == OFS_PER_A)
      rd_val = per_a_r;
    else if (s_axi_araddr == OFS_PER_B)
      rd_val = per_b_r;
    else if (s_axi_araddr == OFS_CNT_A)
      rd_val = cnt_a;
    else if (s_axi_araddr == OFS_CNT_B)
      rd_val = cnt_b;
    else if (s_axi_araddr == OFS_TBC_A)
      rd_val[BIT_RUN] = run_a_r;
    else if (s_axi_araddr == OFS_TBC_B)
      rd_val[BIT_RUN] = run_b_r;
    else if (s_axi_araddr == OFS_IRQ)
    begin
      rd_val[BIT_FLAG] = flag_r;
      rd_val[BIT_IEN] = ien_r;
    end
    else
      rd_err = 1'b1;
  end

  assign wr_err = !(w_ctl || w_pri || w_sec || w_per_a || w_per_b || w_tbc_a || w_tbc_b || w_irq
                    || awaddr_r == OFS_CNT_A || awaddr_r == OFS_CNT_B);

  // axi4-lite handshakes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      aw_free_r <= 1'b1;
      w_free_r <= 1'b1;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && aw_free_r)
      begin
        aw_free_r <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && w_free_r)
      begin
        w_free_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_free_r <= 1'b1;
        w_free_r <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (ar_take)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rd_val};
        s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  assign s_axi_awready = aw_free_r;
  assign s_axi_wready = w_free_r;

  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (rst);

  AST_ONESHOT_LOW: assert property ( // RQ1
    ctl_wr && new_mode == MODE_ONE |=> !compare_output_pin && st_r == st_rise)
    else $error("one-shot setup did not force pin low");
  AST_RISE: assert property ( // RQ2
    active && st_r == st_rise && pri_hit |=> compare_output_pin && st_r == st_fall)
    else $error("primary match did not raise pin");
  AST_FALL: assert property ( // RQ3
    active && st_r == st_fall && sec_hit && one_m |=> !compare_output_pin && st_r == st_done)
    else $error("one-shot trailing edge missing");
  AST_DONE_QUIET: assert property ( // RQ3
    st_r == st_done && !ctl_wr |=> !compare_output_pin && st_r == st_done)
    else $error("extra pulse after one-shot");
  AST_IRQ: assert property ( // RQ4
    irq_req |-> $past(ien_r) && flag_r)
    else $error("interrupt raised without enable");
  AST_REARM: assert property ( // RQ5
    st_r == st_done && ctl_wr && new_mode == MODE_ONE |=> st_r == st_rise ##1 1'b1)
    else $error("one-shot did not re-arm");
  AST_CONT_IRQ: assert property ( // RQ7
    active && cont_m && sec_hit |=> flag_r)
    else $error("continuous mode missed flag");
  AST_DUTY_LOAD: assert property ( // RQ13
    d_load |=> pri_r == $past(sec_r))
    else $error("duty not copied at period match");
  AST_RO: assert property ( // RQ14
    pwm_m && w_pri && !d_load |=> $stable(pri_r))
    else $error("primary written in pwm");
  AST_ZERO: assert property ( // RQ17
    active && st_r == st_pwm && pri_r == RST_REG16 |=> !compare_output_pin)
    else $error("zero duty drove pin high");
  AST_FULL: assert property ( // RQ18
    active && st_r == st_pwm && !flt_blk && pri_r > per_sel && cnt_sel <= per_sel
    |=> compare_output_pin)
    else $error("full duty drove pin low");
  AST_FLT: assert property ( // RQ21
    flt_set |=> flt_r && !compare_output_pin)
    else $error("fault status not set");
  AST_HALT: assert property ( // RQ22
    halted && !ctl_wr |=> $stable(compare_output_pin) && $stable(st_r))
    else $error("channel ran while halted");
endmodule
`default_nettype wire

//--- verification/ocpp_load.sv
// behavioural load on the compare output pin, tallies its activity
`default_nettype none
module ocpp_load
(
  input  wire logic mclk, // clock
  input  wire logic rst,  // sync reset
  input  wire logic pin,  // compare output
  output var  int   hi,   // cycles seen high
  output var  int   rise  // rising edges seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_r;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      hi     <= 0;
      rise   <= 0;
      last_r <= 1'h0;
    end
    else
    begin
      hi     <= hi + int'(pin);
      rise   <= rise + int'(pin && !last_r);
      last_r <= pin;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the output compare channel
`default_nettype none
module tb_top
  import ocpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        fault_in = 1'h0;
  logic        cpu_idle = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, pin, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          hi, rise;
  int          errors = 0;
  int          n_compared = 0;

  ocpp_top uut
  (
    .mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fault_in(fault_in), .cpu_idle(cpu_idle),
    .compare_output_pin(pin), .irq_req(irq)
  );

  ocpp_load load (.mclk(mclk), .rst(rst), .pin(pin), .hi(hi), .rise(rise));

  initial
  begin
    forever #10 mclk = ~mclk;
  end

  task automatic close_out;
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ta, tw, b;
    logic [1:0] r;
    int n;
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    wstrb   <= 4'h3;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    b = 1'h0;
    for (n = 0; n < 50 && !b; n++)
    begin
      #1;
      ta = awready;
      tw = wready;
      b = bvalid;
      r = bresp;
      @(posedge mclk);
      if (ta && awvalid)
        awvalid <= 1'h0;
      if (tw && wvalid)
        wvalid <= 1'h0;
    end
    // bready stays up between writes
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, b;
    int n;
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    b = 1'h0;
    for (n = 0; n < 50 && !b; n++)
    begin
      #1;
      ta = arready;
      b = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta && arvalid)
        arvalid <= 1'h0;
    end
    // rready stays up between reads
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // pin activity over n cycles seen by the load
  task automatic win(input int n, input int eh, input int er);
    int h0, r0;
    #1;
    h0 = hi;
    r0 = rise;
    repeat (n) @(posedge mclk);
    #1;
    chk(32'(hi - h0), 32'(eh));
    chk(32'(rise - r0), 32'(er));
    @(posedge mclk);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    for (int o = 0; o < 40; o += 4)
      rc(8'(o), 32'h0);
    rd(8'h40, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h40, 16'h1234, RESP_SLVERR);
  endtask

  task automatic t_one;
    wr(OFS_PER_A, 16'h0009, RESP_OKAY);
    wr(OFS_PRI, 16'h0002, RESP_OKAY);
    wr(OFS_SEC, 16'h0005, RESP_OKAY);
    wr(OFS_IRQ, 16'h0002, RESP_OKAY);
    wr(OFS_CTL, {13'h0000, MODE_ONE}, RESP_OKAY);
    wr(OFS_TBC_A, 16'h8000, RESP_OKAY);
    win(40, 3, 1);
    rc(OFS_IRQ, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ, 16'h0003, RESP_OKAY);
    win(40, 0, 0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ, 16'h0000, RESP_OKAY);
    wr(OFS_CTL, {13'h0000, MODE_ONE}, RESP_OKAY);
    win(40, 3, 1);
    rc(OFS_IRQ, 32'h1);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_cont;
    wr(OFS_PER_B, 16'h0004, RESP_OKAY);
    wr(OFS_PRI, 16'h0001, RESP_OKAY);
    wr(OFS_SEC, 16'h0003, RESP_OKAY);
    wr(OFS_CTL, {12'h000, 1'h1, MODE_CONT}, RESP_OKAY);
    wr(OFS_TBC_B, 16'h8000, RESP_OKAY);
    win(100, 40, 20);
    wr(OFS_IRQ, 16'h0001, RESP_OKAY);
    cyc(8);
    rc(OFS_IRQ, 32'h1);
  endtask

  task automatic t_pwm;
    int dt[4] = '{0, 8, 7, 5};
    int eh[4] = '{0, 80, 70, 50};
    int er[4] = '{0, 0, 10, 10};
    wr(OFS_PER_B, 16'h0007, RESP_OKAY);
    wr(OFS_SEC, 16'h0003, RESP_OKAY);
    wr(OFS_PRI, 16'h0003, RESP_OKAY);
    wr(OFS_CTL, {12'h000, 1'h1, 3'h6}, RESP_OKAY);
    win(80, 30, 10);
    wr(OFS_PRI, 16'h0005, RESP_OKAY);
    rc(OFS_PRI, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_SEC, 16'(dt[i]), RESP_OKAY);
      cyc(10);
      rc(OFS_PRI, 32'(dt[i]));
      win(80, eh[i], er[i]);
    end
  endtask

  task automatic t_halt;
    cpu_idle <= 1'h1;
    wr(OFS_CTL, 16'h200e, RESP_OKAY);
    win(40, 0, 0);
    cpu_idle <= 1'h0;
    cyc(1);
    win(40, 25, 5);
  endtask

  task automatic t_fault;
    wr(OFS_CTL, {12'h000, 1'h1, MODE_PWMF}, RESP_OKAY);
    // channel interrupt enabled for fault use
    wr(OFS_IRQ, 16'h0003, RESP_OKAY);
    fault_in <= 1'h1;
    cyc(1);
    fault_in <= 1'h0;
    cyc(2);
    rc(OFS_CTL, 32'h001f);
    win(40, 0, 0);
    rc(OFS_IRQ, 32'h3);
    wr(OFS_CTL, 16'h001f, RESP_OKAY);
    rc(OFS_CTL, 32'h000f);
  endtask

  initial
  begin
    #200000;
    errors++;
    close_out;
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    t_reset;
    t_one;
    t_cont;
    t_pwm;
    t_halt;
    t_fault;
    close_out;
  end
endmodule
`default_nettype wire
